// [core/sbp_pkg.sv]
// Constants shared by the slave buffer pointer logic
package sbp_pkg;
    localparam int DATA_W = 8;
    localparam int PTR_W = 5;
    localparam int PAD_W = DATA_W - PTR_W;
    localparam int BUF_DEPTH = 32;
    localparam int FIFO_DEPTH = 16;
    // Register offsets on the CPU I/O port
    localparam logic [7:0] OFS_BUS_BASE = 8'hCB;
    localparam logic [7:0] OFS_BUS_CUR = 8'hCC;
    localparam logic [7:0] OFS_HOST_BASE = 8'hCD;
    localparam logic [7:0] OFS_HOST_CUR = 8'hCE;
    localparam logic [7:0] OFS_BUF_WIN = 8'hCF;
    // Reset values and increment
    localparam logic [PTR_W-1:0] PTR_RST = 5'h00;
    localparam logic [PTR_W-1:0] PTR_STEP = 5'h01;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [PAD_W-1:0] PAD_ZERO = 3'h0;
endpackage : sbp_pkg

// [core/sbp_pointer_logic.sv]
// Buffer FIFO and pointer logic of the RAM-emulation I2C slave
`timescale 1ns/10ps

// ************************************************************
// Write-byte FIFO
// ************************************************************
module sbp_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Filling side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Draining side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] IDX_ONE = AW'(1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic full_q, full_d, empty_q, empty_d;
    logic push, pop;

    always_comb
    begin
        push = in_valid_in && !full_q;
        pop = out_ready_in && !empty_q;
        wr_d = push ? wr_q + IDX_ONE : wr_q;
        rd_d = pop ? rd_q + IDX_ONE : rd_q;
        cnt_d = cnt_q;
        if (push && !pop)
        begin
            cnt_d = cnt_q + CNT_ONE;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - CNT_ONE;
        end
        full_d = (cnt_d == CNT_FULL);
        empty_d = (cnt_d == '0);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            empty_q <= empty_d;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    assign in_ready_out = !full_q;
    assign out_valid_out = !empty_q;
    assign out_data_out = mem_q[rd_q];
endmodule : sbp_fifo

// ************************************************************
// Pointer logic and shared buffer
// ************************************************************
module sbp_pointer_logic (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // CPU I/O register port
    input wire logic [7:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [sbp_pkg::DATA_W-1:0] io_wdata_in,
    output logic [sbp_pkg::DATA_W-1:0] io_rdata_out,
    // Protocol engine events
    input wire logic bus_start_in,
    input wire logic bus_base_load_in,
    input wire logic bus_byte_done_in,
    input wire logic bus_dir_read_in,
    input wire logic [sbp_pkg::DATA_W-1:0] bus_data_in,
    // Protocol engine answers
    output logic [sbp_pkg::DATA_W-1:0] bus_rd_data_out,
    output logic bus_wr_ready_out,
    output logic [sbp_pkg::PTR_W-1:0] bus_cur_ptr_out
);
    import sbp_pkg::*;
    localparam int FW = PTR_W + DATA_W;

    // ************************************************************
    // State
    // ************************************************************
    logic [DATA_W-1:0] buf_q [BUF_DEPTH];
    logic [PTR_W-1:0] bus_base_q, bus_base_d, bus_cur_q, bus_cur_d;
    logic [PTR_W-1:0] host_base_q, host_base_d, host_cur_q, host_cur_d;
    // High from a base write until the next window access
    logic first_q, first_d;
    logic [DATA_W-1:0] rdata_q, rdata_d, bus_rd_q, bus_rd_d;
    logic ready_q;
    logic cpu_base_wr, win_wr, win_rd, bus_push;
    logic fifo_in_ready, fifo_out_valid, drain;
    logic [FW-1:0] fifo_out_data;
    logic buf_we;
    logic [PTR_W-1:0] buf_wa;
    logic [DATA_W-1:0] buf_wd;

    // ************************************************************
    // Bus-side pointers
    // ************************************************************
    always_comb
    begin
        bus_base_d = bus_base_q;
        bus_cur_d = bus_cur_q;
        bus_push = 1'b0;
        if (bus_start_in)
        begin
            bus_cur_d = bus_base_q;
        end
        else if (bus_base_load_in)
        begin
            bus_base_d = bus_data_in[PTR_W-1:0];
            bus_cur_d = bus_data_in[PTR_W-1:0];
        end
        else if (bus_byte_done_in)
        begin
            // Write byte lands at the pointer it arrived under
            bus_push = !bus_dir_read_in;
            bus_cur_d = bus_cur_q + PTR_STEP;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            bus_base_q <= PTR_RST;
            bus_cur_q <= PTR_RST;
        end
        else
        begin
            bus_base_q <= bus_base_d;
            bus_cur_q <= bus_cur_d;
        end
    end

    // ************************************************************
    // Host-side pointers
    // ************************************************************
    always_comb
    begin
        cpu_base_wr = io_wr_in && (io_addr_in == OFS_HOST_BASE);
        win_wr = io_wr_in && (io_addr_in == OFS_BUF_WIN);
        win_rd = io_rd_in && (io_addr_in == OFS_BUF_WIN);
        host_base_d = host_base_q;
        host_cur_d = host_cur_q;
        first_d = first_q;
        if (cpu_base_wr)
        begin
            host_base_d = io_wdata_in[PTR_W-1:0];
            host_cur_d = io_wdata_in[PTR_W-1:0];
            first_d = 1'b1;
        end
        else if (win_wr || win_rd)
        begin
            host_cur_d = host_cur_q + PTR_STEP;
            first_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            host_base_q <= PTR_RST;
            host_cur_q <= PTR_RST;
            first_q <= 1'b0;
        end
        else
        begin
            host_base_q <= host_base_d;
            host_cur_q <= host_cur_d;
            first_q <= first_d;
        end
    end

    // ************************************************************
    // Write-byte FIFO and buffer port
    // ************************************************************
    // Bytes are queued so a CPU window write costs the master a byte only once all 16 FIFO entries are full
    sbp_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .in_valid_in(bus_push),
        .in_data_in({bus_cur_q, bus_data_in}),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(!win_wr)
    );

    always_comb
    begin
        drain = fifo_out_valid && !win_wr;
        buf_we = win_wr || drain;
        buf_wa = win_wr ? host_cur_q : fifo_out_data[FW-1:DATA_W];
        buf_wd = win_wr ? io_wdata_in : fifo_out_data[DATA_W-1:0];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (buf_we)
        begin
            buf_q[buf_wa] <= buf_wd;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb
    begin
        bus_rd_d = buf_q[bus_cur_d];
        case (io_addr_in)
            OFS_BUS_BASE: rdata_d = {PAD_ZERO, bus_base_q};
            OFS_BUS_CUR: rdata_d = {PAD_ZERO, bus_cur_q};
            OFS_HOST_BASE: rdata_d = {PAD_ZERO, host_base_q};
            OFS_HOST_CUR: rdata_d = {PAD_ZERO, host_cur_q};
            OFS_BUF_WIN: rdata_d = buf_q[host_cur_q];
            default: rdata_d = DATA_RST;
        endcase
        if (!io_rd_in)
        begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            rdata_q <= DATA_RST;
            bus_rd_q <= DATA_RST;
            ready_q <= 1'b1;
        end
        else
        begin
            rdata_q <= rdata_d;
            bus_rd_q <= bus_rd_d;
            ready_q <= fifo_in_ready;
        end
    end

    assign io_rdata_out = rdata_q;
    assign bus_rd_data_out = bus_rd_q;
    assign bus_wr_ready_out = ready_q;
    assign bus_cur_ptr_out = bus_cur_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_base_load_copy: assert property (
        bus_base_load_in && !bus_start_in |=>
            bus_cur_q == $past(bus_data_in[PTR_W-1:0]) && bus_cur_q == bus_base_q)
        else $error("current pointer not loaded with base");
    a_bus_byte_step: assert property (
        bus_byte_done_in && !bus_start_in && !bus_base_load_in |=>
            bus_cur_q == $past(bus_cur_q) + PTR_STEP)
        else $error("bus pointer did not step");
    a_write_addr_used: assert property (
        bus_push && fifo_in_ready && !fifo_out_valid && !win_wr |=>
            drain && fifo_out_data == {$past(bus_cur_q), $past(bus_data_in)})
        else $error("write byte not at current pointer");
    a_start_reload: assert property (
        bus_start_in |=> bus_cur_q == $past(bus_base_q))
        else $error("start did not reload pointer");
    a_bus_cur_ro: assert property (
        !bus_start_in && !bus_base_load_in && !bus_byte_done_in |=> $stable(bus_cur_q))
        else $error("bus pointer moved without bus event");
    a_host_base_only: assert property (
        !cpu_base_wr |=> $stable(host_base_q))
        else $error("host base changed without write");
    a_host_base_load: assert property (
        cpu_base_wr |=> host_cur_q == $past(io_wdata_in[PTR_W-1:0])
            && host_base_q == host_cur_q)
        else $error("host pointers not loaded");
    a_window_step: assert property (
        (win_rd || win_wr) && !cpu_base_wr |=> host_cur_q == $past(host_cur_q) + PTR_STEP)
        else $error("host pointer did not step");
    a_window_read: assert property (
        win_rd && !$past(buf_we) |=> io_rdata_out == $past(buf_q[host_cur_q]))
        else $error("window read wrong location");
    a_first_access: assert property (
        (win_rd || win_wr) && first_q |-> host_cur_q == host_base_q)
        else $error("first access not at base");

    c_window_write: cover property (cpu_base_wr ##1 win_wr ##1 win_wr);
    c_start_reload: cover property (bus_base_load_in ##[1:20] bus_start_in);
    c_fifo_full: cover property (!fifo_in_ready);
    c_host_wrap: cover property (win_rd && host_cur_q == '1);
endmodule : sbp_pointer_logic

// [dv/sbp_bus_master_model.sv]
// Behavioural stand-in for the protocol engine facing the bus master
`timescale 1ns/10ps

// ****
// Engine event model
// ****
module sbp_bus_master_model (
    // Clock
    input wire logic clk_in,
    // Engine events
    output logic start_out = 1'b0,
    output logic base_load_out = 1'b0,
    output logic byte_done_out = 1'b0,
    output logic dir_read_out = 1'b0,
    output logic [7:0] data_out = 8'h00
);
    task automatic start();
        @(posedge clk_in);
        start_out <= 1'b1;
        @(posedge clk_in);
        start_out <= 1'b0;
    endtask : start

    // Pointer byte opens every write transaction
    task automatic base(input logic [7:0] v);
        @(posedge clk_in);
        base_load_out <= 1'b1;
        data_out <= v;
        @(posedge clk_in);
        base_load_out <= 1'b0;
        data_out <= ~v;
    endtask : base

    // Released data is inverted so a stale byte never looks valid
    task automatic bytes(input int n, input logic rd, input logic [7:0] d0);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            byte_done_out <= 1'b1;
            dir_read_out <= rd;
            data_out <= d0 + 8'(i);
        end
        @(posedge clk_in);
        byte_done_out <= 1'b0;
        data_out <= ~data_out;
    endtask : bytes
endmodule : sbp_bus_master_model

// [dv/sbp_pointer_logic_tb.sv]
// Self-checking bench for the slave buffer pointer logic
`timescale 1ns/10ps

module sbp_pointer_logic_tb;
    import sbp_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] io_addr_in = 8'h00;
    logic io_wr_in = 1'b0;
    logic io_rd_in = 1'b0;
    logic [DATA_W-1:0] io_wdata_in = 8'h00;
    logic [DATA_W-1:0] io_rdata_out, bus_data_in, bus_rd_data_out;
    logic bus_start_in, bus_base_load_in, bus_byte_done_in, bus_dir_read_in;
    logic bus_wr_ready_out;
    logic [PTR_W-1:0] bus_cur_ptr_out;
    logic saw_full = 1'b0;
    int miscompares = 0;
    int checked = 0;

    initial
    begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    sbp_pointer_logic i_sbp_pointer_logic (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
        .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
        .bus_start_in(bus_start_in), .bus_base_load_in(bus_base_load_in),
        .bus_byte_done_in(bus_byte_done_in), .bus_dir_read_in(bus_dir_read_in),
        .bus_data_in(bus_data_in), .bus_rd_data_out(bus_rd_data_out),
        .bus_wr_ready_out(bus_wr_ready_out), .bus_cur_ptr_out(bus_cur_ptr_out));

    sbp_bus_master_model i_sbp_bus_master_model (.clk_in(ref_clk_in),
        .start_out(bus_start_in), .base_load_out(bus_base_load_in),
        .byte_done_out(bus_byte_done_in), .dir_read_out(bus_dir_read_in),
        .data_out(bus_data_in));

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        io_wr_in <= 1'b1;
        io_addr_in <= a;
        io_wdata_in <= d;
        @(posedge ref_clk_in);
        io_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk_in);
        io_rd_in <= 1'b1;
        io_addr_in <= a;
        @(posedge ref_clk_in);
        io_rd_in <= 1'b0;
        #1 chk(what, exp, io_rdata_out);
    endtask : rd

    always @(posedge ref_clk_in)
        if (bus_wr_ready_out === 1'b0)
            saw_full <= 1'b1;

    // Runs take about 130 cycles; 5000 is ample
    initial
    begin
        #200000;
        miscompares++;
        give_verdict();
    end

    // ****
    // Stimulus
    // ****
    initial
    begin
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(OFS_BUS_CUR, 8'h00, "bus cur");
        rd(OFS_HOST_BASE, 8'h00, "host base");
        rd(OFS_HOST_CUR, 8'h00, "host cur");
        rd(8'h10, 8'h00, "unmapped");
        wr(OFS_HOST_BASE, 8'hFE);
        rd(OFS_HOST_BASE, 8'h1E, "host base");
        rd(OFS_HOST_CUR, 8'h1E, "host cur");
        for (int i = 0; i < 3; i++)
            wr(OFS_BUF_WIN, 8'hA0 + 8'(i));
        rd(OFS_HOST_CUR, 8'h01, "host cur wrap");
        wr(OFS_HOST_CUR, 8'h07);
        rd(OFS_HOST_CUR, 8'h01, "host cur ro");
        wr(OFS_HOST_BASE, 8'h1E);
        for (int i = 0; i < 3; i++)
            rd(OFS_BUF_WIN, 8'hA0 + 8'(i), "window");
        i_sbp_bus_master_model.base(8'hFF);
        #1 chk("bus ptr", 8'h1F, {PAD_ZERO, bus_cur_ptr_out});
        i_sbp_bus_master_model.bytes(2, 1'b0, 8'h55);
        #1 chk("bus ptr", 8'h01, {PAD_ZERO, bus_cur_ptr_out});
        rd(OFS_BUS_CUR, 8'h01, "bus cur");
        i_sbp_bus_master_model.start();
        #1 chk("bus ptr", 8'h1F, {PAD_ZERO, bus_cur_ptr_out});
        chk("bus data", 8'h55, bus_rd_data_out);
        i_sbp_bus_master_model.bytes(1, 1'b1, 8'h00);
        #1 chk("bus data", 8'h56, bus_rd_data_out);
        wr(OFS_HOST_BASE, 8'h1F);
        rd(OFS_BUF_WIN, 8'h55, "window");
        rd(OFS_BUF_WIN, 8'h56, "window");
        wr(OFS_HOST_BASE, 8'h00);
        // Window writes own the buffer, so the bus bytes pile up
        fork
            begin
                @(posedge ref_clk_in);
                io_wr_in <= 1'b1;
                io_addr_in <= OFS_BUF_WIN;
                repeat (24) @(posedge ref_clk_in);
                io_wr_in <= 1'b0;
            end
            i_sbp_bus_master_model.bytes(20, 1'b0, 8'h00);
        join
        chk("fifo full", 8'h01, {7'h00, saw_full});
        chk("bus ptr", 8'h14, {PAD_ZERO, bus_cur_ptr_out});
        repeat (24) @(posedge ref_clk_in);
        #1 chk("fifo drained", 8'h01, {7'h00, bus_wr_ready_out});
        wr(OFS_HOST_BASE, 8'h0F);
        rd(OFS_BUF_WIN, 8'h0F, "drained byte");
        rd(OFS_BUF_WIN, 8'h00, "dropped byte");
        // Second reset in mid-run must clear every pointer again
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(OFS_HOST_BASE, 8'h00, "host base rst");
        rd(OFS_BUS_CUR, 8'h00, "bus cur rst");
        chk("fifo rst", 8'h01, {7'h00, bus_wr_ready_out});
        give_verdict();
    end
endmodule : sbp_pointer_logic_tb
